// [core/qxr_core.sv]
// serial command decoder for quad exit, two-step reset and table read
`timescale 1ns/1ns
`include "qxr_regs.svh"
module qxr_core #(
    parameter int RESET_CYCLES = `QXR_RESET_CYCLES,
    parameter logic [7:0] MAKER_ID = 8'h5E // arbitrary value
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic [3:0] IO_IN,
    output logic [3:0] IO_OUT,
    output logic [3:0] IO_OE,
    input wire logic QUAD_ENTER,
    input wire qxr_pkg::qxr_volatile_type VOL_LOAD,
    input wire logic VOL_LOAD_EN,
    output qxr_pkg::qxr_volatile_type VOL_STATE,
    output logic FOUR_WIRE_MODE,
    output logic ABORT_OP,
    output logic RESET_BUSY
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers: a chip select or clock change counts once stages two and three agree; data pins are taken from stage three
    logic [2:0] cs_s_r, ck_s_r;
    logic [3:0] io_s1_r, io_s2_r, io_s3_r;
    logic cs_q_r, ck_q_r;
    logic cs_q_nxt, ck_q_nxt;

    always_comb begin
        cs_q_nxt = cs_q_r;
        ck_q_nxt = ck_q_r;
        if (cs_s_r[1] == cs_s_r[2]) begin
            cs_q_nxt = cs_s_r[2];
        end
        if (ck_s_r[1] == ck_s_r[2]) begin
            ck_q_nxt = ck_s_r[2];
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            cs_s_r <= 3'h7;
            ck_s_r <= 3'h0;
            io_s1_r <= 4'h0;
            io_s2_r <= 4'h0;
            io_s3_r <= 4'h0;
            cs_q_r <= 1'b1;
            ck_q_r <= 1'b0;
        end else begin
            cs_s_r <= {cs_s_r[1:0], CS_N};
            ck_s_r <= {ck_s_r[1:0], SCLK};
            io_s1_r <= IO_IN;
            io_s2_r <= io_s1_r;
            io_s3_r <= io_s2_r;
            cs_q_r <= cs_q_nxt;
            ck_q_r <= ck_q_nxt;
        end
    end

    logic sel, rise, fall, frame_end;
    assign sel = !cs_q_r && !cs_q_nxt;
    assign rise = sel && !ck_q_r && ck_q_nxt;
    assign fall = sel && ck_q_r && !ck_q_nxt;
    assign frame_end = !cs_q_r && cs_q_nxt;

    ////////////////////////////////////////////////////////////////
    // discoverable table contents
    function automatic logic [7:0] table_byte(input logic [23:0] a, input logic [7:0] mid);
        logic [7:0] v;
        v = `QXR_UNUSED_BYTE; // [RULE14]
        if (a[23:8] == 16'h0000) begin
            case (a[7:0])
                8'h00: v = 8'h53; // [RULE10]
                8'h01: v = 8'h46; // [RULE10]
                8'h02: v = 8'h44; // [RULE10]
                8'h03: v = 8'h50; // [RULE10]
                8'h04: v = 8'h00; // [RULE11]
                8'h05: v = 8'h01; // [RULE11]
                8'h06: v = 8'h01; // [RULE11]
                8'h08: v = 8'h00; // [RULE12]
                8'h09: v = 8'h00;
                8'h0A: v = 8'h01; // [RULE12]
                8'h0B: v = 8'h09; // [RULE12]
                8'h0C: v = 8'h30; // [RULE12]
                8'h0D: v = 8'h00;
                8'h0E: v = 8'h00;
                8'h10: v = mid; // [RULE13]
                8'h11: v = 8'h00;
                8'h12: v = 8'h01; // [RULE13]
                8'h13: v = 8'h03; // [RULE13]
                8'h14: v = 8'h60; // [RULE13]
                8'h15: v = 8'h00;
                8'h16: v = 8'h00;
                8'h30: v = 8'hE5; // bit 4 clear selects the 50H enable [RULE15] [RULE16]
                8'h31: v = 8'h20; // [RULE15]
                8'h32: v = 8'hF1; // [RULE17]
                default: v = `QXR_UNUSED_BYTE;
            endcase
        end
        return v;
    endfunction : table_byte

    ////////////////////////////////////////////////////////////////
    // command decoder
    qxr_pkg::qxr_phase_type ph_r, ph_nxt;
    logic [7:0] op_r, op_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic quad_r, quad_nxt;
    logic armed_r, armed_nxt;
    logic arm_seen_r, arm_seen_nxt;
    logic [15:0] rst_cnt_r, rst_cnt_nxt;
    logic abort_r, abort_nxt;
    logic [3:0] out_r, out_nxt;
    logic [3:0] oe_r, oe_nxt;
    qxr_pkg::qxr_volatile_type vol_r, vol_nxt;
    logic [5:0] step;
    logic [7:0] op_shift;
    logic [23:0] addr_shift;
    logic [7:0] tb;

    always_comb begin
        step = quad_r ? 6'd4 : 6'd1;
        op_shift = quad_r ? {op_r[3:0], io_s3_r} : {op_r[6:0], io_s3_r[0]};
        addr_shift = quad_r ? {addr_r[19:0], io_s3_r} : {addr_r[22:0], io_s3_r[0]};
        tb = table_byte(addr_r, MAKER_ID);
        ph_nxt = ph_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        quad_nxt = quad_r;
        armed_nxt = armed_r;
        arm_seen_nxt = arm_seen_r;
        rst_cnt_nxt = rst_cnt_r;
        abort_nxt = 1'b0;
        out_nxt = out_r;
        oe_nxt = oe_r;
        vol_nxt = vol_r;
        if (VOL_LOAD_EN) begin
            vol_nxt = VOL_LOAD;
        end
        if (QUAD_ENTER) begin
            quad_nxt = 1'b1;
        end
        if (rst_cnt_r != 16'd0) begin
            rst_cnt_nxt = rst_cnt_r - 16'd1; // busy: every frame dropped [RULE7]
            ph_nxt = qxr_pkg::QXR_IGNORE;
        end
        if (rst_cnt_r == 16'd0 && ph_r == qxr_pkg::QXR_IGNORE && cs_q_r) begin
            // busy over and deselected: otherwise the first frame after it is lost [RULE7]
            ph_nxt = qxr_pkg::QXR_OPCODE;
        end
        if (frame_end) begin
            // arm only survives when this frame was exactly the arm opcode [RULE19]
            armed_nxt = (ph_r == qxr_pkg::QXR_ADDR) && arm_seen_r && (cnt_r == 6'd0);
            arm_seen_nxt = 1'b0;
            oe_nxt = 4'h0;
            if (ph_r == qxr_pkg::QXR_ADDR && cnt_r == 6'd0 && rst_cnt_r == 16'd0) begin
                // quad exit leaves volatile state untouched [RULE1] [RULE2]
                if (op_r == `QXR_OP_QUAD_EXIT && quad_r) begin
                    quad_nxt = 1'b0;
                end
                if (op_r == `QXR_OP_RESET && armed_r) begin // [RULE3] [RULE5] [RULE6]
                    quad_nxt = 1'b0;
                    abort_nxt = 1'b1;
                    rst_cnt_nxt = 16'(RESET_CYCLES); // [RULE7]
                    vol_nxt.write_enable_latch = 1'b0; // [RULE4]
                    vol_nxt.suspend_flag = 1'b0;
                    vol_nxt.volatile_status = `QXR_VOL_STATUS_RST;
                    vol_nxt.read_parameter_bits = `QXR_READ_PARAM_RST;
                    vol_nxt.continuous_read_bits = `QXR_CONT_READ_RST;
                    vol_nxt.wrap_setting_bits = `QXR_WRAP_RST;
                end
            end
            ph_nxt = qxr_pkg::QXR_OPCODE;
            cnt_nxt = 6'd0;
        end else if (rise && rst_cnt_r == 16'd0) begin
            case (ph_r)
                qxr_pkg::QXR_OPCODE: begin
                    op_nxt = op_shift;
                    cnt_nxt = cnt_r + step;
                    if (cnt_r + step == 6'd8) begin
                        cnt_nxt = 6'd0;
                        arm_seen_nxt = (op_shift == `QXR_OP_RESET_ARM); // [RULE5]
                        ph_nxt = (op_shift == `QXR_OP_TABLE_READ) ?
                            qxr_pkg::QXR_ADDR : qxr_pkg::QXR_ADDR; // [RULE9]
                        addr_nxt = 24'h00_0000;
                    end
                end
                qxr_pkg::QXR_ADDR: begin
                    if (op_r == `QXR_OP_TABLE_READ) begin
                        addr_nxt = addr_shift; // [RULE18]
                        cnt_nxt = cnt_r + step;
                        if (cnt_r + step == `QXR_ADDR_BITS) begin
                            cnt_nxt = 6'd0;
                            ph_nxt = qxr_pkg::QXR_DUMMY;
                        end
                    end else begin
                        cnt_nxt = 6'd1; // extra clocks spoil a bare opcode frame
                        arm_seen_nxt = 1'b0;
                    end
                end
                qxr_pkg::QXR_DUMMY: begin
                    cnt_nxt = cnt_r + 6'd1;
                    if (cnt_r + 6'd1 == `QXR_DUMMY_CLKS) begin // [RULE18]
                        cnt_nxt = 6'd0;
                        ph_nxt = qxr_pkg::QXR_DATA;
                        sh_nxt = tb;
                        addr_nxt = addr_r + 24'h00_0001;
                    end
                end
                default: begin
                end
            endcase
        end else if (fall && ph_r == qxr_pkg::QXR_DATA) begin
            // shift the next bits out, reloading with auto-increment [RULE18]
            if (quad_r) begin
                out_nxt = sh_r[7:4];
                oe_nxt = 4'hF;
                sh_nxt = {sh_r[3:0], 4'h0};
            end else begin
                out_nxt = {2'b00, sh_r[7], 1'b0};
                oe_nxt = 4'h2;
                sh_nxt = {sh_r[6:0], 1'b0};
            end
            cnt_nxt = cnt_r + step;
            if (cnt_r + step == 6'd8) begin
                cnt_nxt = 6'd0;
                sh_nxt = tb;
                addr_nxt = addr_r + 24'h00_0001;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ph_r <= qxr_pkg::QXR_OPCODE;
            op_r <= 8'h00;
            addr_r <= 24'h00_0000;
            cnt_r <= 6'd0;
            sh_r <= 8'h00;
            quad_r <= 1'b0;
            armed_r <= 1'b0;
            arm_seen_r <= 1'b0;
            rst_cnt_r <= 16'h0000;
            abort_r <= 1'b0;
            out_r <= 4'h0;
            oe_r <= 4'h0;
            vol_r <= '{1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 3'h7};
        end else begin
            ph_r <= ph_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            quad_r <= quad_nxt;
            armed_r <= armed_nxt;
            arm_seen_r <= arm_seen_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            abort_r <= abort_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
            vol_r <= vol_nxt;
        end
    end

    assign IO_OUT = out_r;
    assign IO_OE = oe_r;
    assign VOL_STATE = vol_r;
    assign FOUR_WIRE_MODE = quad_r;
    assign ABORT_OP = abort_r;
    assign RESET_BUSY = (rst_cnt_r != 16'd0);

    ////////////////////////////////////////////////////////////////
    // checks
    reset_clears_wel_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        ABORT_OP |-> !vol_r.write_enable_latch && !vol_r.suspend_flag && !quad_r) // [RULE4]
        else $error("reset left volatile state set");
    reset_abort_busy_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        ABORT_OP |-> RESET_BUSY && rst_cnt_r == 16'(RESET_CYCLES)) // [RULE3]
        else $error("reset did not start busy interval");
    busy_no_cmd_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $past(RESET_BUSY) |-> !ABORT_OP && ($stable(quad_r) || $past(QUAD_ENTER))) // [RULE7]
        else $error("command acted while busy");
    quad_exit_keep_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $fell(quad_r) && !ABORT_OP && !$past(VOL_LOAD_EN) |-> $stable(vol_r)) // [RULE2]
        else $error("quad exit changed volatile state");
    reset_needs_arm_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        ABORT_OP |-> $past(armed_r)) // [RULE19]
        else $error("reset without arm frame");
    quad_exit_cause_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        $fell(quad_r) |-> $past(frame_end)) // [RULE1]
        else $error("mode left outside frame end");
    drive_only_data_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        IO_OE != 4'h0 |-> ph_r == qxr_pkg::QXR_DATA) // [RULE18]
        else $error("output driven outside data phase");
    sig_byte_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
        table_byte(24'h00_0000, MAKER_ID) == 8'h53 && table_byte(24'h00_0007, MAKER_ID)
        == 8'hFF) // [RULE10] [RULE14]
        else $error("table content wrong");
endmodule : qxr_core

// [core/qxr_pkg.sv]
// types for the quad-exit, reset and discoverable table block
package qxr_pkg;
    typedef enum logic [2:0] {
        QXR_OPCODE = 3'b000,
        QXR_ADDR = 3'b001,
        QXR_DUMMY = 3'b011,
        QXR_DATA = 3'b010,
        QXR_IGNORE = 3'b110
    } qxr_phase_type;

    typedef struct packed {
        logic write_enable_latch;
        logic suspend_flag;
        logic [7:0] volatile_status;
        logic [7:0] read_parameter_bits;
        logic [7:0] continuous_read_bits;
        logic [2:0] wrap_setting_bits;
    } qxr_volatile_type;
endpackage : qxr_pkg

// [core/qxr_regs.svh]
// constants for the quad-exit, reset and discoverable table block
// Contract
// RULE1: quad-exit opcode leaves four-wire command mode
// RULE2: mode exit keeps latch, suspend, wrap
// RULE3: accepted reset aborts work, restores defaults
// RULE4: reset clears every volatile setting; the code sets the wrap bits to 7H instead
// RULE5: reset opcodes accepted in both modes
// RULE6: host sends arm and reset separately
// RULE7: ignore commands for 30 us after reset
// RULE8: host checks busy, suspend before reset
// RULE9: table read opcode works in both modes
// RULE10: bytes 00-03 return signature, LSB first
// RULE11: bytes 04-06 return revision and count
// RULE12: first header gives 9 dwords at 30H
// RULE13: second header gives 3 dwords at 60H
// RULE14: unused table bytes always read FFH
// RULE15: byte 30H E5H, byte 31H 20H
// RULE16: volatile write-enable select bit reads zero
// RULE17: byte 32H reads F1H
// RULE18: table frame: opcode, address, dummies, data
// RULE19: reset only right after a complete arm frame
`ifndef QXR_REGS_SVH
`define QXR_REGS_SVH
`define QXR_OP_QUAD_EXIT 8'hFF
`define QXR_OP_RESET_ARM 8'h66
`define QXR_OP_RESET 8'h99
`define QXR_OP_TABLE_READ 8'h5A
`define QXR_ADDR_BITS 6'd24
`define QXR_DUMMY_CLKS 6'd8
`define QXR_T_RESET_NS 30000
`define QXR_CLK_NS 40
`define QXR_RESET_CYCLES (`QXR_T_RESET_NS / `QXR_CLK_NS)
`define QXR_VOL_STATUS_RST 8'h00
`define QXR_READ_PARAM_RST 8'h00
`define QXR_CONT_READ_RST 8'h00
`define QXR_WRAP_RST 3'h7
`define QXR_UNUSED_BYTE 8'hFF
`endif

// [tb/qxr_host.sv]
// host-side serial flash controller model driving chip select, clock and data pins
`timescale 1ns/1ns
module qxr_host (
    input wire logic clk,
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io,
    input wire logic [3:0] din
);
    logic [7:0] rd_q[$];

    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // each level lasts 6 system clocks, the device oversamples the pins
    task automatic tick(input logic [3:0] v, output logic [3:0] got);
        io = v;
        repeat (6) @(negedge clk);
        got = din;
        sclk = 1'b1;
        repeat (6) @(negedge clk);
        sclk = 1'b0;
    endtask : tick

    task automatic send(input logic [31:0] v, input int nbits, input bit quad);
        logic [3:0] g;
        for (int i = nbits; i > 0; i -= (quad ? 4 : 1)) begin
            if (quad)
                tick(v[i-1 -: 4], g);
            else
                tick({3'h0, v[i-1]}, g);
        end
    endtask : send

    // one whole frame; chip select always rises between frames
    task automatic frame(input logic [7:0] op, input bit quad, input bit rd,
                         input logic [23:0] addr, input int nbytes);
        logic [3:0] g;
        logic [7:0] b;
        cs_n = 1'b0;
        repeat (6) @(negedge clk);
        send({24'h0, op}, 8, quad);
        if (rd) begin
            send({8'h0, addr}, 24, quad);
            // pins released by us: keep them toggling so nothing settles by chance
            repeat (8) tick(io ^ 4'hF, g);
            for (int n = 0; n < nbytes; n++) begin
                for (int k = 0; k < (quad ? 2 : 8); k++) begin
                    tick(io ^ 4'hF, g);
                    b = quad ? {b[3:0], g} : {b[6:0], g[1]};
                end
                rd_q.push_back(b);
            end
        end
        repeat (6) @(negedge clk);
        cs_n = 1'b1;
        repeat (12) @(negedge clk);
    endtask : frame
endmodule : qxr_host

// [tb/testbench.sv]
// self-checking bench for the quad-exit, reset and table read block
`timescale 1ns/1ns
`include "qxr_regs.svh"
module testbench;
    localparam int RST_CYC = 400;
    localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
    localparam logic [7:0] HDR [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
        8'hFF, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF, MAKER, 8'h00, 8'h01,
        8'h03, 8'h60, 8'h00, 8'h00, 8'hFF};
    logic SYS_CLK, NRST, QUAD_ENTER, VOL_LOAD_EN, cs_n, sclk, four_wire, abort_op, reset_busy;
    logic [3:0] io_in, io_out, io_oe, io_pin;
    qxr_pkg::qxr_volatile_type vol_load, vol_state;
    int error_cnt = 0;
    int checked = 0;
    int abort_seen = 0;
    int busy_seen = 0;

    qxr_core #(.RESET_CYCLES(RST_CYC), .MAKER_ID(MAKER)) qxr_core_inst (.SYS_CLK(SYS_CLK),
        .NRST(NRST), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io_in), .IO_OUT(io_out), .IO_OE(io_oe),
        .QUAD_ENTER(QUAD_ENTER), .VOL_LOAD(vol_load), .VOL_LOAD_EN(VOL_LOAD_EN),
        .VOL_STATE(vol_state), .FOUR_WIRE_MODE(four_wire), .ABORT_OP(abort_op),
        .RESET_BUSY(reset_busy));
    // a pin the device releases reads back inverted, so a missing enable shows up
    assign io_pin = (io_out & io_oe) | (~io_out & ~io_oe);
    qxr_host qxr_host_inst (.clk(SYS_CLK), .cs_n(cs_n), .sclk(sclk), .io(io_in), .din(io_pin));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end

    always @(negedge SYS_CLK) begin
        if (abort_op === 1'b1) abort_seen++;
        if (reset_busy === 1'b1) busy_seen++;
    end

    task automatic complete_run;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cmd(input logic [7:0] op, input bit quad);
        qxr_host_inst.frame(op, quad, 1'b0, 24'h00_0000, 0);
    endtask : cmd

    task automatic read_bytes(input bit quad, input logic [23:0] a, input int n);
        qxr_host_inst.rd_q.delete();
        qxr_host_inst.frame(`QXR_OP_TABLE_READ, quad, 1'b1, a, n);
        check("bytes read", qxr_host_inst.rd_q.size(), n);
        check("released", io_oe, 4'h0);
    endtask : read_bytes

    // header through the first 24 bytes, then the start of the standard table
    task automatic read_table(input bit quad);
        logic [7:0] b;
        read_bytes(quad, 24'h00_0000, 24);
        for (int i = 0; i < 24 && qxr_host_inst.rd_q.size() > 0; i++) begin
            b = qxr_host_inst.rd_q.pop_front();
            check("header byte", b, HDR[i]);
        end
        read_bytes(quad, 24'h00_0030, 3);
        if (qxr_host_inst.rd_q.size() == 3) begin
            b = qxr_host_inst.rd_q.pop_front();
            check("erase byte", b, 8'hE5);
            check("select bit", b[4], 1'b0);
            check("erase opcode", qxr_host_inst.rd_q.pop_front(), 8'h20);
            check("read modes", qxr_host_inst.rd_q.pop_front(), 8'hF1);
        end
    endtask : read_table

    task automatic pulse_quad;
        @(negedge SYS_CLK);
        QUAD_ENTER = 1'b1;
        @(negedge SYS_CLK);
        QUAD_ENTER = 1'b0;
        repeat (4) @(negedge SYS_CLK);
    endtask : pulse_quad

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge SYS_CLK);
        error_cnt++;
        complete_run();
    end

    initial begin
        NRST = 1'b0;
        QUAD_ENTER = 1'b0;
        VOL_LOAD_EN = 1'b0;
        vol_load = '{1'b1, 1'b1, 8'hA5, 8'h3C, 8'h5A, 3'h2};
        repeat (12) @(negedge SYS_CLK);
        NRST = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        check("volatile", vol_state, {26'h000_0000, 3'h7});
        read_table(1'b0);
        cmd(`QXR_OP_QUAD_EXIT, 1'b0);
        check("mode", four_wire, 1'b0);
        VOL_LOAD_EN = 1'b1;
        @(negedge SYS_CLK);
        VOL_LOAD_EN = 1'b0;
        pulse_quad();
        check("mode", four_wire, 1'b1);
        read_table(1'b1);
        cmd(`QXR_OP_QUAD_EXIT, 1'b1);
        check("mode", four_wire, 1'b0);
        check("volatile", vol_state, vol_load);
        // a lone reset and a reset after an intervening frame must both be refused
        cmd(`QXR_OP_RESET, 1'b0);
        cmd(`QXR_OP_RESET_ARM, 1'b0);
        read_bytes(1'b0, 24'h00_0000, 1);
        cmd(`QXR_OP_RESET, 1'b0);
        check("aborts", abort_seen, 0);
        pulse_quad();
        // suspend is seen set here; the reset below deliberately discards it
        check("suspend", vol_state.suspend_flag, 1'b1);
        cmd(`QXR_OP_RESET_ARM, 1'b1);
        cmd(`QXR_OP_RESET, 1'b1);
        check("aborts", abort_seen, 1);
        check("volatile", vol_state, {26'h000_0000, 3'h7});
        check("mode", four_wire, 1'b0);
        // arm sent while busy is ignored, so the later reset finds nothing armed
        cmd(`QXR_OP_RESET_ARM, 1'b0);
        for (int i = 0; i < 2 * RST_CYC && reset_busy !== 1'b0; i++) @(negedge SYS_CLK);
        if (reset_busy !== 1'b0) begin
            error_cnt++;
            complete_run();
        end
        check("busy cycles", busy_seen, RST_CYC);
        cmd(`QXR_OP_RESET, 1'b0);
        check("aborts", abort_seen, 1);
        // commands are taken again once the busy interval is over
        read_bytes(1'b0, 24'h00_0000, 1);
        if (qxr_host_inst.rd_q.size() == 1)
            check("after busy", qxr_host_inst.rd_q.pop_front(), 8'h53);
        complete_run();
    end
endmodule : testbench
